// *** dv/pci_far_side.sv ***
// Far side model: bus masters, external arbiter, south bridge, clock tree.
`timescale 1ns/100ps
module pci_far_side import pci_arb_pkg::*; (
  // Bench commands
  input wire logic [1:0][MASTER_COUNT-1:0] want,
  input wire logic sb_want,
  input wire logic [1:0] ext_mode,
  input wire logic wide,
  // Bridge grants
  input wire logic [1:0][MASTER_COUNT-1:0] master_bus_grant_n,
  // Far side pins
  output logic [1:0] port_clock_feedback,
  output logic [1:0][MASTER_COUNT-1:0] master_bus_request_n,
  output logic southbridge_bus_request_n,
  output logic [1:0] frame_n,
  output logic [1:0] irdy_n
);
  logic fb_clk = 1'b0;
  logic [1:0] host_grant = 2'h0;
  logic [1:0] frame_q = 2'h3;
  // The clock tree runs free, so the feedback never stops between frames.
  initial begin
    forever #40 fb_clk = ~fb_clk;
  end
  assign port_clock_feedback = {fb_clk, fb_clk};
  assign frame_n = frame_q;
  assign irdy_n = frame_q;
  assign southbridge_bus_request_n = ~sb_want;
  always @(posedge fb_clk) begin
    for (int p = 0; p < 2; p++) begin
      host_grant[p] <= ext_mode[p] && !master_bus_grant_n[p][0];
      frame_q[p] <= (p == 1 && wide) || !(|(~master_bus_grant_n[p] & want[p]));
    end
  end
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      master_bus_request_n[p] = ~want[p];
      if (ext_mode[p]) begin
        master_bus_request_n[p] = {5'h1F, ~host_grant[p]};
      end
    end
  end
endmodule

// *** dv/pci_port_arbitration_assertions.sv ***
// Concurrent checks on the ports of the PCI port arbitration top.
`timescale 1ns/100ps
module pci_port_arbitration_assertions import pci_arb_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Watched ports
  input wire logic [1:0] port_bus_clock,
  input wire logic [1:0][MASTER_COUNT-1:0] master_bus_grant_n,
  input wire logic southbridge_bus_grant_n,
  input wire logic write_snoop_done_n,
  input wire logic ack64_out_n,
  input wire logic [31:0] second_port_addr_data_out,
  input wire logic [3:0] second_port_cmd_byte_en_out,
  input wire logic second_port_parity_out,
  input wire logic [1:0] host_bus_need,
  input wire logic write_posted,
  input wire logic snoop_complete,
  input wire logic [63:0] tx_addr_data,
  input wire logic [7:0] tx_cmd_byte_en,
  input wire logic [1:0] tx_parity,
  input wire logic wide_mode,
  input wire logic [1:0] ext_arb_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_low_gap;
    !port_bus_clock[0] ##1 !port_bus_clock[0] ##1 port_bus_clock[0];
  endsequence
  sequence s_ext_steady;
    ext_arb_mode[0] && $past(ext_arb_mode[0]);
  endsequence

  property p_one_grant;
    $onehot0({~master_bus_grant_n[0], ~southbridge_bus_grant_n});
  endproperty
  property p_port_clk;
    $rose(port_bus_clock[0]) |=> s_low_gap;
  endproperty
  property p_clk_pair;
    port_bus_clock[1] == port_bus_clock[0];
  endproperty
  property p_ext_unused;
    ext_arb_mode[0] |-> &master_bus_grant_n[0][5:1];
  endproperty
  property p_host_req;
    s_ext_steady |=> master_bus_grant_n[0][0] == !$past(host_bus_need[0]);
  endproperty
  property p_ext_no_hold;
    s_ext_steady |-> southbridge_bus_grant_n && write_snoop_done_n;
  endproperty
  property p_wide_port1;
    wide_mode |-> &master_bus_grant_n[1];
  endproperty
  property p_ack_wide;
    !ack64_out_n |-> wide_mode;
  endproperty
  property p_snoop_set;
    snoop_complete && !ext_arb_mode[0] |=> !write_snoop_done_n;
  endproperty
  property p_snoop_clr;
    write_posted && !snoop_complete |=> write_snoop_done_n;
  endproperty
  property p_upper;
    $past(rst_b) |-> {second_port_addr_data_out, second_port_cmd_byte_en_out,
      second_port_parity_out} == $past({tx_addr_data[63:32], tx_cmd_byte_en[7:4], tx_parity[1]});
  endproperty

  a_one_grant: assert property (p_one_grant)
    else $error("more than one grant on port zero");
  a_port_clk: assert property (p_port_clk)
    else $error("port clock not one third of core clock");
  a_clk_pair: assert property (p_clk_pair)
    else $error("port clocks differ");
  a_ext_unused: assert property (p_ext_unused)
    else $error("unused grant asserted in external mode");
  a_host_req: assert property (p_host_req)
    else $error("host request does not follow need");
  a_ext_no_hold: assert property (p_ext_no_hold)
    else $error("hold handshake active in external mode");
  a_wide_port1: assert property (p_wide_port1)
    else $error("port one granted in wide mode");
  a_ack_wide: assert property (p_ack_wide)
    else $error("wide acknowledge outside wide mode");
  a_snoop_set: assert property (p_snoop_set)
    else $error("snoop done not asserted");
  a_snoop_clr: assert property (p_snoop_clr)
    else $error("snoop done not cleared");
  a_upper: assert property (p_upper)
    else $error("upper half not on second port");
endmodule

bind pci_port_arbitration_top pci_port_arbitration_assertions chk_i (.*);

// *** dv/tb_top.sv ***
// Self-checking bench for the PCI port arbitration top.
`timescale 1ns/100ps
module tb_top import pci_arb_pkg::*;;
  logic core_clk, rst_b, wide_bus_strap_n, southbridge_bus_request_n, southbridge_bus_grant_n;
  logic [1:0] ext_arbiter_strap_n, port_bus_clock, port_clock_feedback, frame_n, irdy_n;
  logic [1:0][MASTER_COUNT-1:0] master_bus_request_n, master_bus_grant_n, want;
  logic write_snoop_done_n, sb_want, wide, req64_in_n, req64_out_n, req64_oe_n;
  logic ack64_in_n, ack64_out_n, ack64_oe_n, master_drive, master_can64, target_drive;
  logic target_can64, write_posted, snoop_complete, wide_mode, xfer_is_64;
  logic [31:0] first_port_addr_data_in, first_port_addr_data_out;
  logic [31:0] second_port_addr_data_in, second_port_addr_data_out;
  logic [3:0] first_port_cmd_byte_en_in, first_port_cmd_byte_en_out;
  logic [3:0] second_port_cmd_byte_en_in, second_port_cmd_byte_en_out;
  logic first_port_addr_data_oe_n, first_port_cmd_byte_en_oe_n, first_port_parity_in;
  logic first_port_parity_out, first_port_parity_oe_n, second_port_addr_data_oe_n;
  logic second_port_cmd_byte_en_oe_n, second_port_parity_in, second_port_parity_out;
  logic second_port_parity_oe_n;
  logic [1:0] host_bus_need, tx_parity, tx_drive, bridge_owns_bus, ext_arb_mode, rx_parity;
  logic [1:0] ext_mode;
  logic [63:0] tx_addr_data, rx_addr_data;
  logic [7:0] tx_cmd_byte_en, rx_cmd_byte_en;
  int errors, n_tests;

  assign wide = !wide_bus_strap_n;
  assign ext_mode = ~ext_arbiter_strap_n;
  pci_port_arbitration_top uut (.*);
  pci_far_side far (.*);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic ws, input logic [1:0] xs);
    @(posedge core_clk);
    rst_b <= 1'b0;
    wide_bus_strap_n <= ws;
    ext_arbiter_strap_n <= xs;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    cyc(8);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_grants;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < MASTER_COUNT; k++) begin
        @(posedge core_clk);
        want[p][k] <= 1'b1;
        for (int i = 0; i < 80 && master_bus_grant_n[p][k]; i++) cyc(1);
        chk("grant", master_bus_grant_n[p], 6'(~(6'h01 << k)));
        @(posedge core_clk);
        want[p][k] <= 1'b0;
        for (int i = 0; i < 80 && !master_bus_grant_n[p][k]; i++) cyc(1);
      end
    end
    $display("t_grants done");
  endtask

  task automatic t_rotate;
    int g;
    @(posedge core_clk);
    want[1][3:2] <= 2'h3;
    for (int i = 0; i < 80 && &master_bus_grant_n[1]; i++) cyc(1);
    g = master_bus_grant_n[1][2] ? 3 : 2;
    @(posedge core_clk);
    want[1][g] <= 1'b0;
    for (int i = 0; i < 80 && master_bus_grant_n[1][5 - g]; i++) cyc(1);
    chk("rotated grant", master_bus_grant_n[1], 6'(~(6'h01 << (5 - g))));
    @(posedge core_clk);
    want[1] <= 6'h00;
    cyc(40);
    $display("t_rotate done");
  endtask

  task automatic t_hold_snoop;
    @(posedge core_clk);
    sb_want <= 1'b1;
    for (int i = 0; i < 80 && southbridge_bus_grant_n; i++) cyc(1);
    chk("hold ack", southbridge_bus_grant_n, 1'b0);
    chk("port0 grants", master_bus_grant_n[0], 6'h3F);
    @(posedge core_clk);
    sb_want <= 1'b0;
    snoop_complete <= 1'b1;
    @(posedge core_clk);
    snoop_complete <= 1'b0;
    cyc(1);
    chk("snoop done", write_snoop_done_n, 1'b0);
    @(posedge core_clk);
    write_posted <= 1'b1;
    @(posedge core_clk);
    write_posted <= 1'b0;
    cyc(2);
    chk("snoop cleared", write_snoop_done_n, 1'b1);
    cyc(40);
    $display("t_hold_snoop done");
  endtask

  task automatic t_wide;
    chk("wide mode", wide_mode, 1'b1);
    chk("arb modes", ext_arb_mode, 2'h1);
    @(posedge core_clk);
    second_port_addr_data_in <= 32'hA5C30F96;
    first_port_addr_data_in <= 32'h12345678;
    second_port_cmd_byte_en_in <= 4'h9;
    first_port_cmd_byte_en_in <= 4'h6;
    second_port_parity_in <= 1'b1;
    tx_addr_data <= 64'hFEDCBA9876543210;
    tx_cmd_byte_en <= 8'hC3;
    tx_parity <= 2'h2;
    cyc(5);
    chk("rx data", rx_addr_data, 64'hA5C30F9612345678);
    chk("rx byte enables", rx_cmd_byte_en, 8'h96);
    chk("rx parity", rx_parity, 2'h2);
    chk("data out", {second_port_addr_data_out, first_port_addr_data_out}, 64'hFEDCBA9876543210);
    @(posedge core_clk);
    req64_in_n <= 1'b0;
    target_drive <= 1'b1;
    target_can64 <= 1'b1;
    master_drive <= 1'b1;
    master_can64 <= 1'b1;
    tx_drive <= 2'h1;
    want[1][2] <= 1'b1;
    cyc(6);
    chk("ack64", ack64_out_n, 1'b0);
    chk("req64", req64_out_n, 1'b0);
    chk("xfer64", xfer_is_64, 1'b1);
    chk("oe64", {req64_oe_n, ack64_oe_n}, 2'h0);
    chk("data oe", {first_port_addr_data_oe_n, second_port_addr_data_oe_n}, 2'h0);
    @(posedge core_clk);
    target_can64 <= 1'b0;
    master_can64 <= 1'b0;
    cyc(6);
    chk("ack64 off", ack64_out_n, 1'b1);
    chk("req64 off", req64_out_n, 1'b1);
    chk("xfer64 off", xfer_is_64, 1'b0);
    chk("data oe 32", {first_port_addr_data_oe_n, second_port_addr_data_oe_n}, 2'h1);
    cyc(50);
    chk("port1 refused", master_bus_grant_n[1], 6'h3F);
    $display("t_wide done");
  endtask

  task automatic t_external;
    @(posedge core_clk);
    host_bus_need[0] <= 1'b1;
    sb_want <= 1'b1;
    for (int i = 0; i < 80 && !bridge_owns_bus[0]; i++) cyc(1);
    chk("owns bus", bridge_owns_bus, 2'h3);
    chk("host request", master_bus_grant_n[0], 6'h3E);
    chk("no hold ack", southbridge_bus_grant_n, 1'b1);
    @(posedge core_clk);
    host_bus_need[0] <= 1'b0;
    cyc(2);
    chk("host request off", master_bus_grant_n[0], 6'h3F);
    $display("t_external done");
  endtask

  initial begin
    rst_b = 1'b0;
    {wide_bus_strap_n, ext_arbiter_strap_n, req64_in_n, ack64_in_n} = 5'h1F;
    {want, sb_want, host_bus_need, master_drive, master_can64, target_drive} = '0;
    {target_can64, write_posted, snoop_complete, tx_addr_data, tx_cmd_byte_en} = '0;
    {tx_parity, tx_drive, first_port_addr_data_in, second_port_addr_data_in} = '0;
    {first_port_cmd_byte_en_in, second_port_cmd_byte_en_in} = '0;
    {first_port_parity_in, second_port_parity_in} = '0;
    errors = 0;
    n_tests = 0;
    do_reset(1'b1, 2'h3);
    chk("reset modes", {wide_mode, ext_arb_mode}, 3'h0);
    t_grants();
    t_rotate();
    t_hold_snoop();
    do_reset(1'b0, 2'h2);
    t_wide();
    t_external();
    report_and_stop();
  end

  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
endmodule

// *** rtl/pci_arb_pkg.sv ***
// Shared constants and types for the PCI port arbitration block.
package pci_arb_pkg;
  // Requester layout of one port arbiter.
  localparam int MASTER_COUNT = 6;
  localparam int REQ_COUNT = 8;
  localparam int BRIDGE_IDX = 6;
  localparam int SOUTH_IDX = 7;
  // Port clock is the core clock divided by this ratio.
  localparam int PORT_CLK_RATIO = 3;
  localparam logic [1:0] DIV_LAST = 2'h2;
  // Core cycles after reset release before the straps are captured.
  localparam logic [1:0] STRAP_SETTLE = 2'h3;
  // Reset values: straps read deasserted, so split buses and internal arbitration.
  localparam logic STRAP_RESET = 1'b1;
  localparam logic PIN_IDLE = 1'b1;

  typedef enum logic [2:0] {
    ARB_IDLE = 3'h1,
    ARB_GRANTED = 3'h2,
    ARB_OWNED = 3'h4
  } arb_state_t;
endpackage

// *** rtl/pci_port_arbitration_top.sv ***
// Bus ownership and bus width control for a pair of 32-bit PCI ports.
//
// Notes on behaviour
// - As addressed 64-bit target, drive acknowledge; transfer 64 bits if acknowledged.
// - As 64-bit master, drive request whenever pending transfer can use 64 bits.
// - Wide strap selects two 32-bit buses or one merged 64-bit bus.
// - In merged mode second port data carries the upper doubleword.
// - Unconnected straps read deasserted: split buses, internal arbitration.
// - Upper data, byte enables and parity use second port lines when merged.
// - All other control signals come from the first port when merged.
// - Each port chooses internal or external arbitration on its own.
// - Arbitration strap is taken at reset release; asserted means external.
// - Internal arbiter serves six request inputs and six grant outputs.
// - External mode ignores pairs one to five; pair zero is host grant/request.
// - External mode asserts host request whenever a host transfer needs the bus.
// - South bridge hold, acknowledge and snoop signals act only on port zero.
// - South bridge requests with hold; bridge grants with hold acknowledge.
// - Hold and snoop handshakes are unused under external arbitration.
// - Snoop-complete asserts once snooping of the last memory write finished.
// - Port clock runs at one third of the core clock and times arbitration.
`timescale 1ns/100ps
module pci_port_arbitration_top import pci_arb_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Straps
  input wire logic wide_bus_strap_n,
  input wire logic [1:0] ext_arbiter_strap_n,
  // Port clocks
  output logic [1:0] port_bus_clock,
  input wire logic [1:0] port_clock_feedback,
  // Arbitration pins, index is the port
  input wire logic [1:0][MASTER_COUNT-1:0] master_bus_request_n,
  output logic [1:0][MASTER_COUNT-1:0] master_bus_grant_n,
  input wire logic [1:0] frame_n,
  input wire logic [1:0] irdy_n,
  // South bridge handshake
  input wire logic southbridge_bus_request_n,
  output logic southbridge_bus_grant_n,
  output logic write_snoop_done_n,
  // 64-bit handshake pins
  input wire logic req64_in_n,
  output logic req64_out_n,
  output logic req64_oe_n,
  input wire logic ack64_in_n,
  output logic ack64_out_n,
  output logic ack64_oe_n,
  // First port data pins
  input wire logic [31:0] first_port_addr_data_in,
  output logic [31:0] first_port_addr_data_out,
  output logic first_port_addr_data_oe_n,
  input wire logic [3:0] first_port_cmd_byte_en_in,
  output logic [3:0] first_port_cmd_byte_en_out,
  output logic first_port_cmd_byte_en_oe_n,
  input wire logic first_port_parity_in,
  output logic first_port_parity_out,
  output logic first_port_parity_oe_n,
  // Second port data pins
  input wire logic [31:0] second_port_addr_data_in,
  output logic [31:0] second_port_addr_data_out,
  output logic second_port_addr_data_oe_n,
  input wire logic [3:0] second_port_cmd_byte_en_in,
  output logic [3:0] second_port_cmd_byte_en_out,
  output logic second_port_cmd_byte_en_oe_n,
  input wire logic second_port_parity_in,
  output logic second_port_parity_out,
  output logic second_port_parity_oe_n,
  // Core side requests
  input wire logic [1:0] host_bus_need,
  input wire logic master_drive,
  input wire logic master_can64,
  input wire logic target_drive,
  input wire logic target_can64,
  input wire logic write_posted,
  input wire logic snoop_complete,
  // Core side transmit data, upper half goes to the second port
  input wire logic [63:0] tx_addr_data,
  input wire logic [7:0] tx_cmd_byte_en,
  input wire logic [1:0] tx_parity,
  input wire logic [1:0] tx_drive,
  // Core side status and receive data
  output logic [1:0] bridge_owns_bus,
  output logic wide_mode,
  output logic [1:0] ext_arb_mode,
  output logic xfer_is_64,
  output logic [63:0] rx_addr_data,
  output logic [7:0] rx_cmd_byte_en,
  output logic [1:0] rx_parity
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic wide_s;
  logic [1:0] ext_s, fb_s, frame_s, irdy_s;
  logic [1:0][MASTER_COUNT-1:0] mreq_s;
  logic south_s, req64_s, ack64_s;
  logic [73:0] rx_s;

  pin_sync #(.WIDTH(3), .RESET_LEVEL(STRAP_RESET)) u_strap_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in({wide_bus_strap_n, ext_arbiter_strap_n}),
    .pin_sync_out({wide_s, ext_s})
  );

  pin_sync #(.WIDTH(19), .RESET_LEVEL(PIN_IDLE)) u_ctl_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in({master_bus_request_n, frame_n, irdy_n, southbridge_bus_request_n,
             req64_in_n, ack64_in_n}),
    .pin_sync_out({mreq_s, frame_s, irdy_s, south_s, req64_s, ack64_s})
  );

  pin_sync #(.WIDTH(2), .RESET_LEVEL(1'b0)) u_clk_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in(port_clock_feedback),
    .pin_sync_out(fb_s)
  );

  pin_sync #(.WIDTH(74), .RESET_LEVEL(1'b0)) u_data_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pin_in({second_port_parity_in, first_port_parity_in,
             second_port_cmd_byte_en_in, first_port_cmd_byte_en_in,
             second_port_addr_data_in, first_port_addr_data_in}),
    .pin_sync_out(rx_s)
  );

  // ----------------------------------------------------------------
  // Strap capture and port clock
  // ----------------------------------------------------------------
  logic [1:0] settle, next_settle, div_cnt, next_div_cnt;
  logic strap_done, next_strap_done, next_wide_mode;
  logic [1:0] next_ext_arb_mode, fb_d, tick;

  assign tick = fb_s & ~fb_d;

  always_comb begin
    next_settle = settle;
    next_strap_done = strap_done;
    next_wide_mode = wide_mode;
    next_ext_arb_mode = ext_arb_mode;
    if (!strap_done) begin
      next_settle = settle + 2'h1;
      if (settle == STRAP_SETTLE) begin
        next_strap_done = 1'b1;
        next_wide_mode = ~wide_s;
        next_ext_arb_mode = ~ext_s;
      end
    end
    next_div_cnt = (div_cnt == DIV_LAST) ? 2'h0 : div_cnt + 2'h1;
  end

  // ----------------------------------------------------------------
  // Arbiters
  // ----------------------------------------------------------------
  logic [1:0][REQ_COUNT-1:0] arb_gnt;
  logic [1:0] arb_en;

  for (genvar p = 0; p < 2; p++) begin : g_arb
    logic [REQ_COUNT-1:0] req;
    logic fa, idle;
    // merged bus uses first port control
    assign fa = ~frame_s[0];
    assign idle = frame_s[0] & irdy_s[0];
    // six masters plus bridge and south bridge
    // south bridge only on port zero
    assign req = {(p == 0) ? ~south_s : 1'b0, host_bus_need[p], ~mreq_s[p]};
    assign arb_en[p] = strap_done & ~ext_arb_mode[p] & ((p == 0) | ~wide_mode);

    pci_rr_arbiter u_arb (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .enable(arb_en[p]),
      .tick(tick[p]),
      .req(req),
      .frame_active((p == 0 || wide_mode) ? fa : ~frame_s[p]),
      .bus_idle((p == 0 || wide_mode) ? idle : frame_s[p] & irdy_s[p]),
      .gnt(arb_gnt[p])
    );
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  logic [1:0][MASTER_COUNT-1:0] next_grant_n;
  logic [1:0] next_owns;
  logic next_south_gnt_n, snoop_done, next_snoop_done;
  logic next_req64_out_n, next_req64_oe_n, next_ack64_out_n, next_ack64_oe_n;
  logic next_xfer_is_64, up_drive;

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      if (p == 1 && wide_mode) begin
        next_grant_n[p] = {MASTER_COUNT{1'b1}};
        next_owns[p] = next_owns[0];
      end else if (ext_arb_mode[p]) begin
        // host request on grant line zero
        next_grant_n[p] = {{(MASTER_COUNT-1){1'b1}}, ~host_bus_need[p]};
        // host grant from request line zero
        next_owns[p] = ~mreq_s[p][0];
      end else begin
        next_grant_n[p] = ~arb_gnt[p][MASTER_COUNT-1:0];
        next_owns[p] = arb_gnt[p][BRIDGE_IDX];
      end
    end
    next_south_gnt_n = ~(arb_gnt[0][SOUTH_IDX] & ~ext_arb_mode[0]);
    // completion wins over a new write
    next_snoop_done = snoop_done;
    if (ext_arb_mode[0]) begin
      next_snoop_done = 1'b0;
    end else if (snoop_complete) begin
      next_snoop_done = 1'b1;
    end else if (write_posted) begin
      next_snoop_done = 1'b0;
    end
    next_req64_oe_n = ~(wide_mode & master_drive);
    next_req64_out_n = ~(wide_mode & master_drive & master_can64);
    next_ack64_oe_n = ~(wide_mode & target_drive);
    next_ack64_out_n = ~(wide_mode & target_drive & ~req64_s & target_can64);
    next_xfer_is_64 = wide_mode & ((target_drive & ~req64_s & target_can64) |
                                   (master_drive & ~ack64_s));
    up_drive = wide_mode ? (tx_drive[0] & xfer_is_64) : tx_drive[1];
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      settle <= 2'h0;
      strap_done <= 1'b0;
      wide_mode <= 1'b0;
      ext_arb_mode <= 2'h0;
      div_cnt <= 2'h0;
      port_bus_clock <= 2'h0;
      fb_d <= 2'h0;
      master_bus_grant_n <= '1;
      bridge_owns_bus <= 2'h0;
      southbridge_bus_grant_n <= 1'b1;
      snoop_done <= 1'b0;
      write_snoop_done_n <= 1'b1;
      req64_out_n <= 1'b1;
      req64_oe_n <= 1'b1;
      ack64_out_n <= 1'b1;
      ack64_oe_n <= 1'b1;
      xfer_is_64 <= 1'b0;
      first_port_addr_data_out <= 32'h0;
      first_port_cmd_byte_en_out <= 4'h0;
      first_port_parity_out <= 1'b0;
      first_port_addr_data_oe_n <= 1'b1;
      first_port_cmd_byte_en_oe_n <= 1'b1;
      first_port_parity_oe_n <= 1'b1;
      second_port_addr_data_out <= 32'h0;
      second_port_cmd_byte_en_out <= 4'h0;
      second_port_parity_out <= 1'b0;
      second_port_addr_data_oe_n <= 1'b1;
      second_port_cmd_byte_en_oe_n <= 1'b1;
      second_port_parity_oe_n <= 1'b1;
      rx_addr_data <= 64'h0;
      rx_cmd_byte_en <= 8'h0;
      rx_parity <= 2'h0;
    end else begin
      settle <= next_settle;
      strap_done <= next_strap_done;
      wide_mode <= next_wide_mode;
      ext_arb_mode <= next_ext_arb_mode;
      div_cnt <= next_div_cnt;
      port_bus_clock <= {2{next_div_cnt == 2'h0}};
      fb_d <= fb_s;
      master_bus_grant_n <= next_grant_n;
      bridge_owns_bus <= next_owns;
      southbridge_bus_grant_n <= next_south_gnt_n;
      snoop_done <= next_snoop_done;
      write_snoop_done_n <= ~next_snoop_done;
      req64_out_n <= next_req64_out_n;
      req64_oe_n <= next_req64_oe_n;
      ack64_out_n <= next_ack64_out_n;
      ack64_oe_n <= next_ack64_oe_n;
      xfer_is_64 <= next_xfer_is_64;
      first_port_addr_data_out <= tx_addr_data[31:0];
      first_port_cmd_byte_en_out <= tx_cmd_byte_en[3:0];
      first_port_parity_out <= tx_parity[0];
      first_port_addr_data_oe_n <= ~tx_drive[0];
      first_port_cmd_byte_en_oe_n <= ~tx_drive[0];
      first_port_parity_oe_n <= ~tx_drive[0];
      second_port_addr_data_out <= tx_addr_data[63:32];
      second_port_cmd_byte_en_out <= tx_cmd_byte_en[7:4];
      second_port_parity_out <= tx_parity[1];
      second_port_addr_data_oe_n <= ~up_drive;
      second_port_cmd_byte_en_oe_n <= ~up_drive;
      second_port_parity_oe_n <= ~up_drive;
      rx_addr_data <= rx_s[63:0];
      rx_cmd_byte_en <= rx_s[71:64];
      rx_parity <= rx_s[73:72];
    end
  end
endmodule

// *** rtl/pci_rr_arbiter.sv ***
// Rotating-priority arbiter for one PCI port.
`timescale 1ns/100ps
module pci_rr_arbiter import pci_arb_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic enable,
  input wire logic tick,
  input wire logic [REQ_COUNT-1:0] req,
  input wire logic frame_active,
  input wire logic bus_idle,
  // Grant
  output logic [REQ_COUNT-1:0] gnt
);
  arb_state_t state, next_state;
  logic [REQ_COUNT-1:0] next_gnt;
  logic [2:0] last, next_last;
  logic [3:0] pick;

  // Searches from the requester after the last owner, so the owner comes last.
  function automatic logic [3:0] pick_next(input logic [REQ_COUNT-1:0] r,
                                           input logic [2:0] from);
    logic [3:0] res;
    logic [2:0] idx;
    res = 4'h0;
    for (int i = REQ_COUNT; i >= 1; i--) begin
      idx = from + 3'(i);
      if (r[idx]) begin
        res = {1'b1, idx};
      end
    end
    return res;
  endfunction

  always_comb begin
    pick = pick_next(req, last);
    next_state = state;
    next_gnt = gnt;
    next_last = last;
    if (!enable) begin
      next_state = ARB_IDLE;
      next_gnt = '0;
    end else if (tick) begin
      unique case (state)
        ARB_IDLE: begin
          if (pick[3]) begin
            next_gnt = REQ_COUNT'(1) << pick[2:0];
            next_last = pick[2:0];
            next_state = ARB_GRANTED;
          end
        end
        ARB_GRANTED: begin
          if (frame_active) begin
            next_state = ARB_OWNED;
          end else if (!req[last] && bus_idle) begin
            next_gnt = '0;
            next_state = ARB_IDLE;
          end
        end
        ARB_OWNED: begin
          if (pick[3]) begin
            next_gnt = REQ_COUNT'(1) << pick[2:0];
            next_last = pick[2:0];
            next_state = ARB_GRANTED;
          end else begin
            next_gnt = '0;
            next_state = ARB_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ARB_IDLE;
      gnt <= '0;
      last <= 3'h7;
    end else begin
      state <= next_state;
      gnt <= next_gnt;
      last <= next_last;
    end
  end
endmodule

// *** rtl/pin_sync.sv ***
// Two flip-flop synchroniser for a vector of pins.
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic RESET_LEVEL = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= {WIDTH{RESET_LEVEL}};
      pin_sync_out <= {WIDTH{RESET_LEVEL}};
    end else begin
      stage1 <= pin_in;
      pin_sync_out <= stage1;
    end
  end
endmodule
